/* File: common/brf_pkg.sv */
// package for the brake, regen and fault sequencer: register map, field
// positions, thresholds and timing constants.
// assumes a 250 MHz system clock and DC-link voltage measured in whole volts.
package brf_pkg;
	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_KHZ       = 250000;
	localparam int unsigned ENA_DELAY_MS  = 100;
	localparam int unsigned RAMP_MS       = 10;
	localparam int unsigned CHECK_MS      = 2;
	localparam int unsigned ENA_DELAY_CYC = ENA_DELAY_MS * CLK_KHZ;
	localparam int unsigned RAMP_CYC      = RAMP_MS * CLK_KHZ;
	localparam int unsigned CHECK_CYC     = CHECK_MS * CLK_KHZ;
	localparam logic [6:0]  BRAKE_PCT     = 7'h03;
	localparam logic [6:0]  PCT_FULL      = 7'h64;

	// ----------------------------------------------------------------
	// register map and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_FCLR    = 8'h04;
	localparam logic [7:0] OFS_STATUS  = 8'h08;
	localparam logic [7:0] OFS_MASK    = 8'h0C;
	localparam logic [7:0] OFS_STATE   = 8'h10;
	localparam logic [7:0] OFS_AVG_LIM = 8'h14;
	localparam logic [7:0] OFS_PK_LIM  = 8'h18;
	localparam int CTRL_BRAKE  = 0;
	localparam int CTRL_GERR   = 1;
	localparam int CTRL_SUP_LO = 2;
	localparam int CTRL_SUP_HI = 3;
	localparam int CTRL_SHARED = 4;
	localparam int CTRL_W      = 5;
	localparam int EVT_OV      = 0;
	localparam int EVT_REGEX   = 1;
	localparam int EVT_BRAKE   = 2;
	localparam int EVT_DONE    = 3;
	localparam int EVT_W       = 4;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	localparam logic [15:0]       LIM_RST  = 16'hFFFF;

	// ----------------------------------------------------------------
	// DC-link thresholds in volts, per supply class
	// ----------------------------------------------------------------
	localparam logic [10:0] ON_LO_230  = 11'h190;
	localparam logic [10:0] ON_LO_400  = 11'h2D0;
	localparam logic [10:0] ON_LO_480  = 11'h348;
	localparam logic [10:0] OFF_LO_230 = 11'h17C;
	localparam logic [10:0] OFF_LO_400 = 11'h2A8;
	localparam logic [10:0] OFF_LO_480 = 11'h320;
	localparam logic [10:0] OV_230     = 11'h1C2;
	localparam logic [10:0] OV_400     = 11'h320;
	localparam logic [10:0] OV_480     = 11'h384;
	localparam logic [4:0]  TRIM_MAX   = 5'h1E;

	typedef enum logic [1:0] {
		SUP_230 = 2'b00,
		SUP_400 = 2'b01,
		SUP_480 = 2'b10
	} brf_supply_e;

	typedef enum logic [1:0] {
		ST_OFF   = 2'b00,
		ST_RUN   = 2'b01,
		ST_STOP  = 2'b10,
		ST_FAULT = 2'b11
	} brf_state_e;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} brf_bus_s;
endpackage

/* File: hdl/brf_sequencer.sv */
// brake disable sequencer, regen switch and DC-link fault supervisor.
// assumes synchronous inputs on clk_sys and a master that never waits.
//
// Overview of operation
// - brake output only when brake selected
// - hold power stage 100 ms after disable
// - ramp speed setpoint to zero in 10 ms
// - apply brake at 3% of start speed
// - regen starts at class response level
// - switch-on window 30 V per class
// - regen stops at lower switch-off level
// - regen overload flags status, disables regen
// - periodic check trips overvoltage error, shutdown
// - ready contact opens with overvoltage trip
// - shared link adapts regen thresholds automatically
// - lowest switch-off unit performs shared trip
// - any fault stops stage, opens contact
// - optional global error output on fault
// - brake selected uses sequenced disable
`timescale 1ns/10ps
`default_nettype none
module brf_sequencer
	import brf_pkg::*;
#(
	parameter int unsigned DELAY_CYC = ENA_DELAY_CYC,
	parameter int unsigned RAMP_LEN  = RAMP_CYC,
	parameter int unsigned CHK_CYC   = CHECK_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire brf_bus_s    busReq,
	output var  logic [31:0] busRdata,
	input  wire logic        enableIn,
	input  wire logic [15:0] speedSetIn,
	input  wire logic [15:0] speedMeas,
	input  wire logic [10:0] dcLinkVolts,
	input  wire logic [15:0] regenPowerAvg,
	input  wire logic [15:0] regenPowerPeak,
	input  wire logic        extFault,
	input  wire logic        peerLowerOff,
	output var  logic [15:0] speedSetOut,
	output var  logic        powerStageOn,
	output var  logic        brakeOut,
	output var  logic        regenOn,
	output var  logic        driveReadyContact,
	output var  logic        dcLinkOvervoltageError,
	output var  logic        globalError,
	output var  logic        irq
);
	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rstMeta_r, rstN;

	// release is synchronised so no flop leaves reset a cycle apart
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta_r <= 1'b0;
			rstN      <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstN      <= rstMeta_r;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstN);

	// ----------------------------------------------------------------
	// threshold lookup
	// ----------------------------------------------------------------
	// class 2'b11 is unused and falls back to the highest supply
	function automatic logic [10:0] pickVolt(input logic [1:0] sup, input logic [10:0] a,
		input logic [10:0] b, input logic [10:0] c);
		pickVolt = (sup == SUP_230) ? a : (sup == SUP_400) ? b : c;
	endfunction

	// ----------------------------------------------------------------
	// state and registers
	// ----------------------------------------------------------------
	brf_state_e        state_r, state_nxt;
	logic [CTRL_W-1:0] ctrl_r;
	logic [EVT_W-1:0]  status_r, mask_r;
	logic [15:0]       avgLim_r, pkLim_r, startSet_r, startSpd_r;
	logic [31:0]       delayCnt_r, rampLeft_r, chkCnt_r;
	logic [4:0]        trim_r;
	logic              ovLatch_r, regenInhibit_r, brakeCmd_r;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire         wrCtrl    = busReq.wr && busReq.addr == OFS_CTRL;
	wire         wrFclr    = busReq.wr && busReq.addr == OFS_FCLR && busReq.wdata[0];
	wire         wrStatus  = busReq.wr && busReq.addr == OFS_STATUS;
	wire         wrMask    = busReq.wr && busReq.addr == OFS_MASK;
	wire         wrAvg     = busReq.wr && busReq.addr == OFS_AVG_LIM;
	wire         wrPk      = busReq.wr && busReq.addr == OFS_PK_LIM;
	wire         brakeSel  = ctrl_r[CTRL_BRAKE];
	wire         shared    = ctrl_r[CTRL_SHARED];
	wire [1:0]   supply    = ctrl_r[CTRL_SUP_HI:CTRL_SUP_LO];
	wire         chkTick   = chkCnt_r == CHK_CYC - 1;
	// shared link: thresholds ride up by the trim inside the 30 V window
	wire [10:0]  onTh      = pickVolt(supply, ON_LO_230, ON_LO_400, ON_LO_480)
	                         + {6'h00, trim_r};
	wire [10:0]  offTh     = pickVolt(supply, OFF_LO_230, OFF_LO_400, OFF_LO_480)
	                         + {6'h00, trim_r};
	wire [10:0]  ovTh      = pickVolt(supply, OV_230, OV_400, OV_480);
	// in a shared group only the unit with the lowest switch-off level trips
	wire         ovTrip    = chkTick && dcLinkVolts >= ovTh
	                         && !(shared && peerLowerOff);
	wire         regenEx   = regenOn && (regenPowerAvg > avgLim_r
	                         || regenPowerPeak > pkLim_r);
	wire         ovNxt     = (ovLatch_r && !wrFclr) || ovTrip;
	wire         faultNxt  = ovNxt || extFault;
	wire         stRun     = state_r == ST_RUN;
	wire         stStop    = state_r == ST_STOP;
	wire         delayDone = delayCnt_r == DELAY_CYC - 1;
	wire [22:0]  spdScaled = speedMeas * PCT_FULL;
	wire [22:0]  spdLimit  = startSpd_r * BRAKE_PCT;
	wire         speedLow  = spdScaled <= spdLimit;
	wire [47:0]  rampProd  = startSet_r * rampLeft_r;
	wire [47:0]  rampQuot  = rampProd / RAMP_LEN;
	wire [15:0]  rampVal   = rampQuot[15:0];
	wire         brakeEvt  = stStop && speedLow && !brakeCmd_r;
	wire         doneEvt   = stStop && delayDone && !faultNxt;
	wire         regenSet  = !regenInhibit_r && dcLinkVolts >= onTh;
	wire         regenClr  = regenEx || regenInhibit_r || dcLinkVolts <= offTh;
	wire         regenNxt  = regenClr ? 1'b0 : (regenSet ? 1'b1 : regenOn);
	wire [EVT_W-1:0] evt   = {doneEvt, brakeEvt, regenEx && !regenInhibit_r, ovTrip};
	// set beats the write-one clear in the same cycle
	wire [EVT_W-1:0] statusNxt = (status_r & ~(wrStatus ? busReq.wdata[EVT_W-1:0]
	                             : {EVT_W{1'b0}})) | evt;
	wire [31:0]  stateWord = {20'h00000, trim_r, !driveReadyContact || extFault,
	                         driveReadyContact, powerStageOn, regenOn, 1'b0, state_r};
	wire [31:0]  rdMux     = busReq.addr == OFS_CTRL    ? {27'h0000000, ctrl_r}
	                       : busReq.addr == OFS_STATUS  ? {28'h0000000, status_r}
	                       : busReq.addr == OFS_MASK    ? {28'h0000000, mask_r}
	                       : busReq.addr == OFS_STATE   ? stateWord
	                       : busReq.addr == OFS_AVG_LIM ? {16'h0000, avgLim_r}
	                       : busReq.addr == OFS_PK_LIM  ? {16'h0000, pkLim_r}
	                       : 32'h00000000;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// a fault overrides any sequence in progress, no braked ramp on a trip
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_OFF: begin
				if (faultNxt) state_nxt = ST_FAULT;
				else if (enableIn) state_nxt = ST_RUN;
			end
			ST_RUN: begin
				if (faultNxt) state_nxt = ST_FAULT;
				else if (!enableIn) state_nxt = brakeSel ? ST_STOP : ST_OFF;
			end
			ST_STOP: begin
				if (faultNxt) state_nxt = ST_FAULT;
				else if (delayDone) state_nxt = ST_OFF;
			end
			ST_FAULT: begin
				if (!faultNxt && !enableIn) state_nxt = ST_OFF;
			end
		endcase
	end

	// sequence timers, captured start values and outputs
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			state_r           <= ST_OFF;
			delayCnt_r        <= '0;
			rampLeft_r        <= '0;
			startSet_r        <= '0;
			startSpd_r        <= '0;
			brakeCmd_r        <= 1'b1;
			speedSetOut       <= '0;
			powerStageOn      <= 1'b0;
			brakeOut          <= 1'b0;
			driveReadyContact <= 1'b0;
			globalError       <= 1'b0;
		end else begin
			state_r           <= state_nxt;
			delayCnt_r        <= stStop ? delayCnt_r + 32'h1 : '0;
			rampLeft_r        <= stRun ? RAMP_LEN : (rampLeft_r != 0 ? rampLeft_r - 32'h1 : '0);
			startSet_r        <= stRun ? speedSetIn : startSet_r;
			startSpd_r        <= stRun ? speedMeas : startSpd_r;
			brakeCmd_r        <= (state_nxt != ST_RUN) && (brakeCmd_r || brakeEvt
			                     || state_nxt != ST_STOP);
			speedSetOut       <= stRun ? speedSetIn : (stStop ? rampVal : '0);
			powerStageOn      <= state_nxt == ST_RUN || state_nxt == ST_STOP;
			brakeOut          <= brakeSel && (state_nxt != ST_RUN) && (brakeCmd_r
			                     || brakeEvt || state_nxt != ST_STOP);
			driveReadyContact <= !faultNxt;
			globalError       <= faultNxt && ctrl_r[CTRL_GERR];
		end
	end

	// ----------------------------------------------------------------
	// DC-link supervision and regen
	// ----------------------------------------------------------------
	// trim walks one volt per check so load shares out between units
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			chkCnt_r               <= '0;
			trim_r                 <= '0;
			ovLatch_r              <= 1'b0;
			regenInhibit_r         <= 1'b0;
			regenOn                <= 1'b0;
			dcLinkOvervoltageError <= 1'b0;
		end else begin
			chkCnt_r               <= chkTick ? '0 : chkCnt_r + 32'h1;
			if (!shared) trim_r <= '0;
			else if (chkTick && regenOn && trim_r < TRIM_MAX) trim_r <= trim_r + 5'h01;
			else if (chkTick && !regenOn && trim_r != 0) trim_r <= trim_r - 5'h01;
			ovLatch_r              <= ovNxt;
			regenInhibit_r         <= (regenInhibit_r && !wrFclr) || regenEx;
			regenOn                <= regenNxt;
			dcLinkOvervoltageError <= ovNxt;
		end
	end

	// ----------------------------------------------------------------
	// register slave and interrupt
	// ----------------------------------------------------------------
	// read data stands in the cycle after the strobe only
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			ctrl_r   <= CTRL_RST;
			status_r <= '0;
			mask_r   <= '0;
			avgLim_r <= LIM_RST;
			pkLim_r  <= LIM_RST;
			busRdata <= '0;
			irq      <= 1'b0;
		end else begin
			if (wrCtrl) ctrl_r <= busReq.wdata[CTRL_W-1:0];
			if (wrMask) mask_r <= busReq.wdata[EVT_W-1:0];
			if (wrAvg) avgLim_r <= busReq.wdata[15:0];
			if (wrPk) pkLim_r <= busReq.wdata[15:0];
			status_r <= statusNxt;
			busRdata <= busReq.rd ? rdMux : 32'h00000000;
			irq      <= |(statusNxt & mask_r);
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_brake_needs_sel: assert property (brakeOut |-> $past(brakeSel))
		else $error("brake driven without brake selection");
	a_stop_stage_on: assert property ((stRun || stStop) == powerStageOn)
		else $error("power stage does not follow sequencer state");
	a_delay_length: assert property ($fell(stStop) && $past(!faultNxt)
		|-> $past(delayCnt_r) == DELAY_CYC - 1)
		else $error("disable delay ended at wrong count");
	a_ramp_ends_zero: assert property (stStop && rampLeft_r == 0 |=> speedSetOut == 0)
		else $error("setpoint not zero at end of ramp");
	a_brake_at_low: assert property (stStop && speedLow && brakeSel && !faultNxt
		|=> brakeOut)
		else $error("brake not applied at low speed");
	a_regen_on_level: assert property ($rose(regenOn) |-> $past(dcLinkVolts >= onTh))
		else $error("regen started below switch-on level");
	a_regen_overload: assert property (regenEx |=> !regenOn ##1 !regenOn)
		else $error("regen kept on after overload");
	a_ov_shutdown: assert property (ovTrip |=> dcLinkOvervoltageError
		&& !powerStageOn && !driveReadyContact)
		else $error("overvoltage trip did not shut down");
	a_ready_with_ov: assert property (dcLinkOvervoltageError |-> !driveReadyContact)
		else $error("ready contact closed during overvoltage");
	a_fault_stage_off: assert property (extFault |=> !powerStageOn && !driveReadyContact)
		else $error("fault left stage or contact on");
	a_global_err: assert property (faultNxt && ctrl_r[CTRL_GERR] |=> globalError)
		else $error("global error not raised");
	a_nobrake_direct: assert property (stRun && !enableIn && !brakeSel && !faultNxt
		|=> state_r == ST_OFF)
		else $error("no-brake disable not immediate");
endmodule
`default_nettype wire

/* File: tb/brf_partner_model.sv */
// partner model: higher-level control and motor with its holding brake.
// assumes the same clock and reset as the sequencer it faces.
`timescale 1ns/10ps
`default_nettype none
module brf_partner_model (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        enableReq,
	input  wire logic        driveReadyContact,
	input  wire logic        globalError,
	input  wire logic        powerStageOn,
	input  wire logic        brakeOut,
	input  wire logic [15:0] speedSetOut,
	output logic             enableIn,
	output logic [15:0]      speedMeas
);
	// ----------------------------------------------------------------
	// control and motor
	// ----------------------------------------------------------------
	// control drops enable once the contact opens or an error shows
	assign enableIn = enableReq & driveReadyContact & ~globalError;
	// motor tracks the setpoint one cycle late; coasting never quite stops,
	// so only the brake brings it to rest
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			speedMeas <= 16'h0000;
		end else if (brakeOut) begin
			speedMeas <= 16'h0000;
		end else if (powerStageOn) begin
			speedMeas <= speedSetOut;
		end else begin
			speedMeas <= speedMeas - (speedMeas >> 3);
		end
	end
endmodule
`default_nettype wire

/* File: tb/brf_sequencer_tb_top.sv */
// bench for the sequencer: bus tasks and one task per scenario.
// assumes the partner model stands in for the control and the motor.
`timescale 1ns/10ps
`default_nettype none
module brf_sequencer_tb_top
	import brf_pkg::*;
;
	// short counts keep the run brief
	localparam int DLY = 200;
	localparam int RMP = 20;
	localparam int CHK = 16;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	brf_bus_s    busReq = '0;
	logic [31:0] busRdata, rd;
	logic        enableReq = 1'b0;
	logic        enableIn, powerStageOn, brakeOut, regenOn, driveReadyContact;
	logic        dcLinkOvervoltageError, globalError, irq;
	logic [15:0] speedSetIn = 16'h03E8;
	logic [15:0] speedMeas, speedSetOut;
	logic [10:0] dcLinkVolts = 11'h000;
	logic [15:0] regenPowerAvg = 16'h0000;
	logic [15:0] regenPowerPeak = 16'h0000;
	logic        extFault = 1'b0;
	logic        peerLowerOff = 1'b0;
	// the fourth supply code is unused and must act as the highest class
	logic [10:0] onTh [4] = '{ON_LO_230, ON_LO_400, ON_LO_480, ON_LO_480};
	logic [10:0] offTh [4] = '{OFF_LO_230, OFF_LO_400, OFF_LO_480, OFF_LO_480};
	logic [10:0] ovTh [4] = '{OV_230, OV_400, OV_480, OV_480};
	int          fail_count = 0;
	int          checked = 0;
	int          cycles = 0;

	brf_sequencer #(.DELAY_CYC(DLY), .RAMP_LEN(RMP), .CHK_CYC(CHK)) brf_sequencer_inst (
		.clk_sys(clk_sys), .reset_n(reset_n), .busReq(busReq), .busRdata(busRdata),
		.enableIn(enableIn), .speedSetIn(speedSetIn), .speedMeas(speedMeas),
		.dcLinkVolts(dcLinkVolts), .regenPowerAvg(regenPowerAvg),
		.regenPowerPeak(regenPowerPeak), .extFault(extFault), .peerLowerOff(peerLowerOff),
		.speedSetOut(speedSetOut), .powerStageOn(powerStageOn), .brakeOut(brakeOut),
		.regenOn(regenOn), .driveReadyContact(driveReadyContact),
		.dcLinkOvervoltageError(dcLinkOvervoltageError), .globalError(globalError), .irq(irq));
	brf_partner_model brf_partner_model_inst (
		.clk_sys(clk_sys), .reset_n(reset_n), .enableReq(enableReq),
		.driveReadyContact(driveReadyContact), .globalError(globalError),
		.powerStageOn(powerStageOn), .brakeOut(brakeOut), .speedSetOut(speedSetOut),
		.enableIn(enableIn), .speedMeas(speedMeas));

	// ----------------------------------------------------------------
	// clock, watchdog and shared tasks
	// ----------------------------------------------------------------
	always #2 clk_sys = ~clk_sys;
	// a hang ends the run as a mismatch
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fail_count++;
			summarize();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic busWr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		busReq.wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic busRd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		busReq.rd <= 1'b0;
		#1 d = busRdata;
	endtask
	task automatic setV(input logic [10:0] v);
		@(posedge clk_sys);
		dcLinkVolts <= v;
		cyc(3);
	endtask
	task automatic run();
		@(posedge clk_sys);
		enableReq <= 1'b1;
		cyc(5);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		busRd(OFS_CTRL, rd);
		chk("ctrl", 32'h0, rd);
		busRd(OFS_AVG_LIM, rd);
		chk("avgLim", 32'hFFFF, rd);
		busRd(OFS_PK_LIM, rd);
		chk("pkLim", 32'hFFFF, rd);
		busWr(8'h1C, 32'hFFFF);
		busRd(8'h1C, rd);
		chk("unmapped", 32'h0, rd);
		busWr(OFS_STATE, 32'hFFFF);
		busRd(OFS_STATE, rd);
		chk("state", 32'h20, rd);
		cyc(1);
		chk("rdIdle", 32'h0, busRdata);
	endtask
	task automatic t_nobrake();
		busWr(OFS_CTRL, 32'h0);
		run();
		@(posedge clk_sys);
		enableReq <= 1'b0;
		cyc(3);
		chk("stageOff", 1'b0, powerStageOn);
		chk("brakeUnused", 1'b0, brakeOut);
	endtask
	// sequenced disable: hold time, ramp shape and brake point
	task automatic t_brake();
		int n;
		logic [15:0] prevSet, p1;
		busWr(OFS_CTRL, 32'h1);
		run();
		@(posedge clk_sys);
		enableReq <= 1'b0;
		prevSet = 16'h03E8;
		p1 = speedMeas;
		for (n = 0; n < DLY + 10 && powerStageOn === 1'b1; n++) begin
			cyc(1);
			if (n < RMP + 2) chk("rampMono", 1'b1, speedSetOut <= prevSet);
			if (n == RMP / 2) chk("rampMid", 1'b1, speedSetOut inside {[400:600]});
			if (n == RMP + 2) chk("rampEnd", 32'h0, speedSetOut);
			if (n == RMP + 6) chk("brakeSet", 1'b1, brakeOut);
			if (brakeOut === 1'b1 && p1 > 16'd30) chk("brakeEarly", 32'd30, p1);
			prevSet = speedSetOut;
			p1 = speedMeas;
		end
		chk("holdLen", 1'b1, n >= DLY && n <= DLY + 2);
		chk("brakeHeld", 1'b1, brakeOut);
		busRd(OFS_STATUS, rd);
		chk("statusDone", 2'b11, rd[3:2]);
		busWr(OFS_STATUS, 32'hF);
	endtask
	task automatic t_regen();
		for (int i = 0; i < 4; i++) begin
			busWr(OFS_CTRL, 32'(i << CTRL_SUP_LO));
			setV(onTh[i] - 11'h001);
			chk("regenBelow", 1'b0, regenOn);
			setV(onTh[i]);
			chk("regenOn", 1'b1, regenOn);
			setV(offTh[i] + 11'h001);
			chk("regenHyst", 1'b1, regenOn);
			setV(offTh[i]);
			chk("regenOff", 1'b0, regenOn);
		end
		setV(11'h000);
	endtask
	task automatic t_overload();
		busWr(OFS_CTRL, 32'h0);
		busWr(OFS_AVG_LIM, 32'h00000064);
		busWr(OFS_PK_LIM, 32'h000000C8);
		setV(11'h19A);
		@(posedge clk_sys);
		regenPowerAvg <= 16'h0065;
		cyc(3);
		chk("avgTrip", 1'b0, regenOn);
		busRd(OFS_STATUS, rd);
		chk("statusOver", 1'b1, rd[1]);
		@(posedge clk_sys);
		regenPowerAvg <= 16'h0000;
		cyc(3);
		chk("inhibit", 1'b0, regenOn);
		busWr(OFS_FCLR, 32'h1);
		cyc(3);
		chk("reArm", 1'b1, regenOn);
		@(posedge clk_sys);
		regenPowerPeak <= 16'h00C9;
		cyc(3);
		chk("peakTrip", 1'b0, regenOn);
		@(posedge clk_sys);
		regenPowerPeak <= 16'h0000;
		setV(11'h000);
		busWr(OFS_FCLR, 32'h1);
		busWr(OFS_STATUS, 32'hF);
	endtask
	// trip per class: within CHK + 3 cycles of the level, with contact, error and irq
	task automatic t_ov();
		int n;
		for (int i = 0; i < 3; i++) begin
			busWr(OFS_CTRL, 32'((i << CTRL_SUP_LO) | 2));
			run();
			setV(ovTh[i] - 11'h001);
			cyc(3 * CHK);
			chk("noTrip", 1'b0, dcLinkOvervoltageError);
			@(posedge clk_sys);
			dcLinkVolts <= ovTh[i];
			for (n = 0; n < CHK + 3 && dcLinkOvervoltageError !== 1'b1; n++) cyc(1);
			chk("ovTrip", 1'b1, dcLinkOvervoltageError);
			chk("readyOpen", 1'b0, driveReadyContact);
			chk("stageTrip", 1'b0, powerStageOn);
			chk("gerrOn", 1'b1, globalError);
			chk("irqMasked", 1'b0, irq);
			busWr(OFS_MASK, 32'h1);
			cyc(1);
			chk("irqOn", 1'b1, irq);
			setV(11'h000);
			busWr(OFS_STATUS, 32'h1);
			busWr(OFS_FCLR, 32'h1);
			cyc(3);
			chk("irqClr", 1'b0, irq);
			chk("ovClr", 1'b0, dcLinkOvervoltageError);
			chk("readyBack", 1'b1, driveReadyContact);
			busWr(OFS_MASK, 32'h0);
		end
		enableReq <= 1'b0;
	endtask
	task automatic t_ext();
		busWr(OFS_CTRL, 32'h1);
		run();
		@(posedge clk_sys);
		extFault <= 1'b1;
		cyc(2);
		chk("extStage", 1'b0, powerStageOn);
		chk("extReady", 1'b0, driveReadyContact);
		chk("extBrake", 1'b1, brakeOut);
		chk("gerrOff", 1'b0, globalError);
		@(posedge clk_sys);
		extFault <= 1'b0;
		enableReq <= 1'b0;
		cyc(3);
		chk("extBack", 1'b1, driveReadyContact);
	endtask
	task automatic t_shared();
		int n;
		busWr(OFS_CTRL, 32'h12);
		peerLowerOff <= 1'b1;
		setV(OV_230);
		cyc(4 * CHK);
		chk("peerTrip", 1'b0, dcLinkOvervoltageError);
		busRd(OFS_STATE, rd);
		chk("trim", 1'b1, rd[11:7] > 0 && rd[11:7] <= TRIM_MAX);
		@(posedge clk_sys);
		peerLowerOff <= 1'b0;
		for (n = 0; n < CHK + 3 && dcLinkOvervoltageError !== 1'b1; n++) cyc(1);
		chk("lowTrip", 1'b1, dcLinkOvervoltageError);
		chk("lowReady", 1'b0, driveReadyContact);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		cyc(4);
		t_regs();
		t_nobrake();
		t_brake();
		t_regen();
		t_overload();
		t_ov();
		t_ext();
		t_shared();
		summarize();
	end
endmodule
`default_nettype wire
